// *** cc_source_params.svh ***
// Purpose: Constants for the source-side CC controller.
// Assumes: 40 MHz system clock, AXI4-Lite register access.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
//
// Functional notes
// [RQ1] Pull-ups on both CC lines, strength selectable
// [RQ2] Low select level advertises default current
// [RQ3] Middle select level advertises 1.5 A
// [RQ4] High select level advertises 3 A
// [RQ5] Attach low on sink and VBUS below 800 mV
// [RQ6] CC1 termination pulls orientation output low
// [RQ7] CC2 termination releases orientation output high
// [RQ8] Unattached mode two states, active one state
// [RQ9] Start unattached until attach is confirmed
// [RQ10] Unattached mode keeps monitoring both CC lines
// [RQ11] Confirmed attach moves to active mode
// [RQ12] Active mode shows attach; leaves on removal
// [RQ13] No cable electronic marking support
// [RQ14] System provides VBUS discharge externally
// [RQ15] Old dual-role partners need not work
// [RQ16] Unconnected VBUS sense needs system guarantee
// [RQ17] Debounce CC attach for 168 ms
// [RQ18] Debounce VBUS sense for 2 ms
// [RQ19] Attach indicator open drain, low while attached
// [RQ20] Current select may change during operation
// [RQ21] Termination loss returns to unattached, releases
// [RQ22] Orientation held while attached, set on attach
`ifndef CC_SOURCE_PARAMS_SVH
`define CC_SOURCE_PARAMS_SVH
`define CLK_HZ            40000000
`define CC_DEBOUNCE_MS    168
`define VBUS_DEBOUNCE_MS  2
`define CC_DEBOUNCE_CYC   ((`CLK_HZ / 1000) * `CC_DEBOUNCE_MS)
`define VBUS_DEBOUNCE_CYC ((`CLK_HZ / 1000) * `VBUS_DEBOUNCE_MS)
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_ID            12'h008
`define CTRL_RESET        32'h0000_0000
`define ID_VALUE          32'h0000_5A01
`endif

// *** cc_source_pkg.sv ***
// Purpose: Types for the source-side CC controller.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Holds the advertisement levels and the state machine type.
package cc_source_pkg;
    // Current advertisement, Rp strength on both CC lines
    typedef enum logic [1:0] {
        ADV_DEFAULT = 2'h0,
        ADV_MEDIUM  = 2'h1,
        ADV_HIGH    = 2'h2
    } adv_t;
    // Connection states of the source
    typedef enum logic [1:0] {
        ST_UNATTACHED,
        ST_ATTACH_WAIT,
        ST_ATTACHED
    } cc_state_t;
    // Open-drain pin drive
    typedef struct packed {
        logic attachOe;
        logic orientOe;
    } od_t;
endpackage

// *** cc_source_ctrl.sv ***
// Purpose: CC attach, orientation and current advertisement logic.
// Assumes: CC comparators and select level decoder are analog, outside.
// Notes:   Registers over AXI4-Lite; open-drain outputs as enables.
`timescale 1ns/100ps
`default_nettype none
`include "cc_source_params.svh"
module cc_source_ctrl #(
    parameter int CC_DB_CYC   = `CC_DEBOUNCE_CYC,
    parameter int VBUS_DB_CYC = `VBUS_DEBOUNCE_CYC,
    parameter logic [31:0] ID_VALUE = `ID_VALUE // arbitrary value
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        cc1SinkSeen,
    input  wire logic        cc2SinkSeen,
    input  wire logic        modeSelMid,
    input  wire logic        modeSelHigh,
    input  wire logic        vbus_sense_in,
    output logic [1:0]       rpSelect,
    output logic             rpEnable,
    output logic             attach_indicator_n,
    output logic             attachOe,
    output logic             orientOut,
    output logic             orientOe,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        logic [1:0]             sync1;
        logic [1:0]             sync2;
        logic [1:0]             mSync1;
        logic [1:0]             mSync2;
        logic                   vSync1;
        logic                   vSync2;
        cc_source_pkg::cc_state_t st;
        logic [31:0]            ccCnt;
        logic [31:0]            vCnt;
        logic                   vbusLow;
        logic                   onCc2;
        cc_source_pkg::adv_t    adv;
        logic [1:0]             ctrl;
        logic                   awDone;
        logic                   wDone;
        logic                   wrEn;
        logic                   bValid;
        logic [1:0]             bResp;
        logic                   rValid;
        logic [31:0]            rData;
        logic [1:0]             rResp;
    } st_t;

    st_t cur;
    st_t next_cur;
    logic ccAny;
    logic vbusRaw;

    // ****************************************************
    // Next state
    // ****************************************************
    // Pins are synchronised twice before anything looks at them
    always_comb begin
        next_cur        = cur;
        next_cur.sync1  = {cc2SinkSeen, cc1SinkSeen};
        next_cur.sync2  = cur.sync1;
        next_cur.mSync1 = {modeSelHigh, modeSelMid};
        next_cur.mSync2 = cur.mSync1;
        next_cur.vSync1 = vbus_sense_in;
        next_cur.vSync2 = cur.vSync1;
        ccAny   = |cur.sync2; // [RQ10]
        vbusRaw = cur.vSync2;

        // Select level may move at any time; Rp follows it while ctrl bit 1 is clear [RQ20]
        if (cur.ctrl[1]) begin
            next_cur.adv = cc_source_pkg::adv_t'(cur.ctrl[0] ?
                cc_source_pkg::ADV_HIGH : cc_source_pkg::ADV_DEFAULT);
        end else if (cur.mSync2[1]) begin
            next_cur.adv = cc_source_pkg::ADV_HIGH; // [RQ4]
        end else if (cur.mSync2[0]) begin
            next_cur.adv = cc_source_pkg::ADV_MEDIUM; // [RQ3]
        end else begin
            next_cur.adv = cc_source_pkg::ADV_DEFAULT; // [RQ2]
        end

        // VBUS low flag needs 2 ms of stable low sense [RQ18]
        if (vbusRaw) begin
            next_cur.vCnt    = '0;
            next_cur.vbusLow = 1'b0;
        end else if (cur.vCnt < 32'(VBUS_DB_CYC)) begin
            next_cur.vCnt = cur.vCnt + 32'd1;
        end else begin
            next_cur.vbusLow = 1'b1;
        end

        // Connection state machine; no cable marking handling [RQ13]
        case (cur.st) // [RQ8]
            cc_source_pkg::ST_UNATTACHED: begin
                // Source only, never toggles roles like a dual-role port [RQ15]
                next_cur.ccCnt = '0;
                if (ccAny) begin
                    next_cur.st = cc_source_pkg::ST_ATTACH_WAIT;
                end
            end
            cc_source_pkg::ST_ATTACH_WAIT: begin
                if (!ccAny) begin
                    next_cur.st = cc_source_pkg::ST_UNATTACHED;
                end else if (cur.ccCnt < 32'(CC_DB_CYC)) begin
                    next_cur.ccCnt = cur.ccCnt + 32'd1; // [RQ17]
                end else if (cur.vbusLow) begin
                    // Orientation latched once per attach [RQ22]
                    next_cur.onCc2 = !cur.sync2[0]; // [RQ6] [RQ7]
                    next_cur.st    = cc_source_pkg::ST_ATTACHED; // [RQ11]
                end
            end
            cc_source_pkg::ST_ATTACHED: begin
                // Only the latched line counts; a swap means removal
                if (!(cur.onCc2 ? cur.sync2[1] : cur.sync2[0])) begin
                    next_cur.st = cc_source_pkg::ST_UNATTACHED; // [RQ21]
                end
            end
            default: begin
                next_cur.st = cc_source_pkg::ST_UNATTACHED;
            end
        endcase

        // AXI write: address and data in either order
        next_cur.wrEn = 1'b0;
        if (s_axi_awvalid && !cur.awDone && !cur.bValid) begin
            next_cur.awDone = 1'b1;
        end
        if (s_axi_wvalid && !cur.wDone && !cur.bValid) begin
            next_cur.wDone = 1'b1;
        end
        if (cur.awDone && cur.wDone && !cur.bValid) begin
            next_cur.awDone = 1'b0;
            next_cur.wDone  = 1'b0;
            next_cur.bValid = 1'b1;
            next_cur.bResp  = 2'h0;
            next_cur.wrEn   = 1'b1;
        end
        if (cur.bValid && s_axi_bready) begin
            next_cur.bValid = 1'b0;
        end

        // AXI read answers one cycle after the address is taken
        if (s_axi_arvalid && !cur.rValid) begin
            next_cur.rValid = 1'b1;
            next_cur.rResp  = 2'h0;
            case (s_axi_araddr)
                `REG_CTRL:   next_cur.rData = {30'h0, cur.ctrl};
                `REG_STATUS: next_cur.rData = {24'h0, cur.adv, cur.onCc2,
                    cur.vbusLow, cur.sync2, cur.st};
                `REG_ID:     next_cur.rData = ID_VALUE;
                default: begin
                    next_cur.rData = 32'h0000_0000;
                    next_cur.rResp = 2'h2;
                end
            endcase
        end else if (cur.rValid && s_axi_rready) begin
            next_cur.rValid = 1'b0;
        end
    end

    // Write address and data are held in flops until both have arrived
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic        wLane0;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            awAddr <= 12'h000;
            wData  <= 32'h0000_0000;
            wLane0 <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData  <= s_axi_wdata;
                wLane0 <= s_axi_wstrb[0];
            end
        end
    end

    // ****************************************************
    // Registers
    // ****************************************************
    // Reset lands in unattached mode, pins released [RQ9]
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cur       <= '0;
            cur.st    <= cc_source_pkg::ST_UNATTACHED;
            cur.adv   <= cc_source_pkg::ADV_DEFAULT;
            cur.ctrl  <= 2'(`CTRL_RESET);
            cur.bResp <= 2'h0;
        end else begin
            cur <= next_cur;
            // Late write lands the cycle after the response is raised
            if (cur.wrEn && awAddr == `REG_CTRL && wLane0) begin
                cur.ctrl <= wData[1:0];
            end
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    // Both pull-ups always on, strength from the advertisement [RQ1]
    assign rpEnable = 1'b1;
    assign rpSelect = cur.adv;
    // Attach indicator pulls low only while attached [RQ5] [RQ12] [RQ19]
    assign attachOe           = (cur.st == cc_source_pkg::ST_ATTACHED);
    assign attach_indicator_n = 1'b0;
    // Low for CC1, released high for CC2
    assign orientOe  = (cur.st == cc_source_pkg::ST_ATTACHED) && !cur.onCc2;
    assign orientOut = 1'b0;
    assign s_axi_awready = !cur.awDone && !cur.bValid;
    assign s_axi_wready  = !cur.wDone && !cur.bValid;
    assign s_axi_bvalid  = cur.bValid;
    assign s_axi_bresp   = cur.bResp;
    assign s_axi_arready = !cur.rValid;
    assign s_axi_rvalid  = cur.rValid;
    assign s_axi_rdata   = cur.rData;
    assign s_axi_rresp   = cur.rResp;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    attach_needs_vbus_a: assert property ( // [RQ5]
        $rose(attachOe) |-> $past(cur.vbusLow))
        else $error("attach without vbus low");
    attach_needs_cc_a: assert property ( // [RQ11]
        $rose(attachOe) |-> $past(cur.st) == cc_source_pkg::ST_ATTACH_WAIT
            && $past(cur.ccCnt) >= 32'(CC_DB_CYC))
        else $error("attach before debounce");
    orient_stable_a: assert property ( // [RQ22]
        attachOe && $past(attachOe) |-> $stable(orientOe))
        else $error("orientation changed while attached");
    detach_release_a: assert property ( // [RQ21]
        attachOe && !(cur.onCc2 ? cur.sync2[1] : cur.sync2[0])
            |=> !attachOe)
        else $error("no release on detach");
    adv_high_a: assert property ( // [RQ4]
        !cur.ctrl[1] && cur.mSync2[1] |=> rpSelect == 2'h2)
        else $error("high select not advertised");
    adv_mid_a: assert property ( // [RQ3]
        !cur.ctrl[1] && cur.mSync2 == 2'b01 |=> rpSelect == 2'h1)
        else $error("mid select not advertised");
    adv_def_a: assert property ( // [RQ2]
        !cur.ctrl[1] && cur.mSync2 == 2'b00 |=> rpSelect == 2'h0)
        else $error("default not advertised");
    vbus_clear_a: assert property ( // [RQ18]
        vbusRaw |=> !cur.vbusLow)
        else $error("vbus low flag kept");
    rp_both_a: assert property ( // [RQ1]
        rpEnable)
        else $error("pull-ups dropped");
    orient_cc1_a: assert property ( // [RQ6]
        $rose(attachOe) && $past(cur.sync2[0]) |-> orientOe)
        else $error("cc1 orientation wrong");
    orient_cc2_a: assert property ( // [RQ7]
        $rose(attachOe) && !$past(cur.sync2[0]) |-> !orientOe)
        else $error("cc2 orientation wrong");

    attach_cc1_c: cover property ($rose(attachOe) && orientOe);
    attach_cc2_c: cover property ($rose(attachOe) && !orientOe);
    detach_c:     cover property ($fell(attachOe));
    axi_rd_c:     cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// *** cc_sink_model.sv ***
// Purpose: Sink device and system VBUS rail facing the CC controller.
// Assumes: Rd is seen only while the source pull-ups are on.
// Notes:   VBUS switch follows the attach pin; discharge is slow.
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Sink device and VBUS rail model
// ****************************************
module cc_sink_model #(
    parameter int DISCH_CYC = 6
) (
    input  wire logic       clk_sys,
    input  wire logic       plugged,
    input  wire logic       flipped,
    input  wire logic       vbusStale,
    input  wire logic       rpEnable,
    input  wire logic [1:0] rpSelect,
    input  wire logic       attachOe,
    output logic            cc1SinkSeen,
    output logic            cc2SinkSeen,
    output logic            vbus_sense_in,
    output int              advMa
);
    int   dischCnt = 0;
    logic vbusUp   = 1'b0;
    // Rd only shows through a plugged cable, on the facing pin
    assign cc1SinkSeen   = plugged & ~flipped & rpEnable;
    assign cc2SinkSeen   = plugged & flipped & rpEnable;
    assign vbus_sense_in = vbusUp | vbusStale; // Stale charge left on rail
    // Advertised current as the sink reads it
    always_comb begin
        case (rpSelect)
            2'h1: advMa = 1500;
            2'h2: advMa = 3000;
            default: advMa = 500;
        endcase
    end
    // Rail switched on only by the indicator; bleeds off slowly after
    always @(posedge clk_sys) begin
        if (attachOe) begin
            vbusUp   <= 1'b1;
            dischCnt <= DISCH_CYC;
        end else if (dischCnt > 0) begin
            dischCnt <= dischCnt - 1;
        end else begin
            vbusUp <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** typec_source_cc_controller_bench.sv ***
// Purpose: Self-checking bench for the source CC controller.
// Assumes: Short debounce parameters; sink model on the CC side.
// Notes:   Expected counts derive from CC_DB and VB_DB below.
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Bench top
// ****************************************
module typec_source_cc_controller_bench;
    localparam int          CC_DB  = 20;
    localparam int          VB_DB  = 10;
    localparam logic [31:0] ID_VAL = 32'h0000_C3A7; // arbitrary value
    logic clk_sys = 1'b0, rstn = 1'b0, plugged = 1'b0, flipped = 1'b0;
    logic vbusStale = 1'b0, modeSelMid = 1'b0, modeSelHigh = 1'b0;
    logic cc1SinkSeen, cc2SinkSeen, vbus_sense_in, rpEnable;
    logic attach_indicator_n, attachOe, orientOut, orientOe;
    logic [1:0]  rpSelect, s_axi_bresp, s_axi_rresp, r;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    int   advMa, n, i, t, mismatches = 0, n_checks = 0;
    int   maTab [4] = '{500, 1500, 3000, 3000};
    always #12.5 clk_sys = ~clk_sys; // 40 MHz
    cc_source_ctrl #(.CC_DB_CYC(CC_DB), .VBUS_DB_CYC(VB_DB),
        .ID_VALUE(ID_VAL)) DUT (.*);
    cc_sink_model SINK (.*);
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            mismatches++;
        end
    endtask
    // Hold each channel until its ready is sampled high
    task automatic axiWr(input logic [11:0] a, input logic [31:0] v);
        t = 0;
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= v;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            t++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && t < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRd(input logic [11:0] a);
        t = 0;
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            t++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && t < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Bounded wait on the attach pin, counting cycles
    task automatic waitAtt(input logic v);
        n = 0;
        while (attachOe !== v && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog: whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        $display("BAD watchdog expired");
        final_report;
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        chk("attachOe", 32'h0, attachOe);
        chk("rpEnable", 32'h1, rpEnable);
        chk("pinLevel", 32'h0, attach_indicator_n);
        chk("orientLevel", 32'h0, orientOut);
        axiRd(12'h008);
        chk("id", ID_VAL, d);
        axiRd(12'h00C);
        chk("badRsp", 32'h2, r);
        chk("badData", 32'h0, d);
        axiWr(12'h010, 32'h0000_0003);
        chk("wrRsp", 32'h0, r);
        $display("test reset done");
        // Every select level, changed on the fly
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            {modeSelHigh, modeSelMid} <= i[1:0];
            repeat (10) @(posedge clk_sys);
            chk("advMa", maTab[i], advMa);
        end
        modeSelHigh <= 1'b0;
        axiWr(12'h000, 32'h0000_0003);
        repeat (3) @(posedge clk_sys);
        chk("override", 32'h2, 32'(rpSelect));
        axiWr(12'h000, 32'h0000_0000);
        repeat (3) @(posedge clk_sys);
        chk("pinsBack", 32'h1, 32'(rpSelect));
        $display("test current done");
        // Short bounce must not attach
        plugged <= 1'b1;
        repeat (CC_DB / 2) @(posedge clk_sys);
        plugged <= 1'b0;
        repeat (3 * CC_DB) @(posedge clk_sys);
        chk("bounce", 32'h0, attachOe);
        // Sink present but rail not yet safe
        vbusStale <= 1'b1;
        plugged   <= 1'b1;
        repeat (3 * CC_DB) @(posedge clk_sys);
        chk("vbusHigh", 32'h0, attachOe);
        axiRd(12'h004);
        chk("waitState", 32'h1, d[1:0]);
        vbusStale <= 1'b0;
        waitAtt(1'b1);
        chk("vbusDb", 32'h1, n >= VB_DB && n <= VB_DB + 12);
        chk("cc1Orient", 32'h1, orientOe);
        axiRd(12'h004);
        chk("attState", 32'h2, d[1:0]);
        plugged <= 1'b0;
        waitAtt(1'b0);
        chk("detach", 32'h1, n <= 6);
        $display("test cc1 attach done");
        // Flipped plug after the rail has drained
        repeat (40) @(posedge clk_sys);
        flipped <= 1'b1;
        plugged <= 1'b1;
        waitAtt(1'b1);
        chk("ccDb", 32'h1, n >= CC_DB && n <= CC_DB + 12);
        chk("cc2Orient", 32'h0, orientOe);
        plugged <= 1'b0;
        waitAtt(1'b0);
        chk("detach2", 32'h1, n <= 6);
        $display("test cc2 attach done");
        final_report;
    end
endmodule
`default_nettype wire
